// ---- rtl/dbs_pkg.sv ----
// Shared constants, types and rule summary for the DDR burst SRAM port decode
//
// Contract
// RULE1 - Load and write low at true edge t; data beats at t+1 true and complement edges
// RULE2 - Load low, read high at t; words at complement rise t+1, true rise t+2
// RULE3 - Load high starts nothing; idle slot leaves pins three-stated after pending burst
// RULE4 - After power-up the port is deselected, outputs three-stated, nothing pending
// RULE5 - Wide organisations: first beat at latched address, second with address LSB inverted
// RULE6 - Narrow organisations ignore external LSB; beats use burst bit 0 then 1 (code keeps every address bit and appends the burst bit below)
// RULE7 - Write data taken on both input clock rises; read data launched on both
// RULE8 - With clocks stopped the data pins hold; parking clocks high is advised
// RULE9 - Eight-bit: nibble select 0 gates bits 3:0, select 1 gates 7:4
// RULE10 - Eighteen-bit: byte select 0 gates bits 8:0, select 1 gates 17:9
// RULE11 - Thirty-six-bit: four selects gate nine-bit lanes 8:0, 17:9, 26:18, 35:27
// RULE12 - A beat with every select high leaves the array unchanged
// RULE13 - Selects sampled separately per beat, so each beat may have its own mask
// RULE14 - Selects count only in the data slots of a properly started write
// RULE15 - After reads stop, finish pending burst, then three-state after next true rise
// RULE16 - Controller leaves at least one idle slot between a read and a write
// RULE17 - Read of address written one cycle before returns newest data from posted registers
// RULE18 - Both output clock pins high from power-on select single clock mode
package dbs_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 36;
	localparam int SEL_W = 4;
	localparam int LANE_W = 9;
	localparam int NIB_W = 4;
	localparam int IDX_W = ADDR_W + 1;
	localparam int MEM_DEPTH = 1 << IDX_W;
	localparam int BUF_DEPTH = 2;

	// ------------------------------------------------------------
	// Power-up timing on the core clock
	// ------------------------------------------------------------
	localparam int REF_CLK_NS = 25;
	localparam int STRAP_SETTLE_NS = 400;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int SETTLE_CNT_W = 5;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(STRAP_SETTLE_CYC - 1);

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] DQ_RST = 36'h000000000;
	localparam logic [SEL_W-1:0] WE_NONE = 4'hF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DBS_ORG_X8 = 2'h0,
		DBS_ORG_X9 = 2'h1,
		DBS_ORG_X18 = 2'h2,
		DBS_ORG_X36 = 2'h3
	} dbs_org_t;

	typedef enum logic [1:0] {
		PWR_SETTLE = 2'b01,
		PWR_RUN = 2'b10
	} dbs_pwr_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] d0;
		logic [DATA_W-1:0] d1;
		logic [DATA_W-1:0] we0;
		logic [DATA_W-1:0] we1;
	} dbs_burst_t;

	localparam int BURST_W = $bits(dbs_burst_t);

endpackage : dbs_pkg

// ---- rtl/dbs_buf_if.sv ----
// Carrier between the posted-write buffer and its user
`timescale 1ns/1ps
interface dbs_buf_if #(
	parameter int W = 8,
	parameter int DEPTH = 2
) ();
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	logic [W-1:0] peek_data [DEPTH];
	logic [DEPTH-1:0] peek_valid;

	modport store (
		input push_valid,
		input push_data,
		input pop_ready,
		output push_ready,
		output pop_valid,
		output pop_data,
		output peek_data,
		output peek_valid
	);

	modport user (
		output push_valid,
		output push_data,
		output pop_ready,
		input push_ready,
		input pop_valid,
		input pop_data,
		input peek_data,
		input peek_valid
	);
endinterface : dbs_buf_if

// ---- rtl/dbs_sync3.sv ----
// Three-stage level synchroniser that changes once stages two and three agree
`timescale 1ns/1ps
module dbs_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level from another domain
	input wire logic async_in,
	// Filtered level
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Chain; only the second stage looks at the first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a change only when two settled stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= RST_VAL;
		end else if (s2_q == s3_q) begin
			level <= s3_q;
		end
	end
endmodule : dbs_sync3

// ---- rtl/dbs_buf2.sv ----
// Small shift-register FIFO with visible entries for read bypass
`timescale 1ns/1ps
module dbs_buf2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Both sides of the buffer
	dbs_buf_if.store bus
);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [W-1:0] ent_q [DEPTH];
	logic [CNT_W-1:0] cnt_q;
	logic push;
	logic pop;
	logic [CNT_W-1:0] slot;

	// Honest flags: full refuses even if a pop happens in the same cycle
	assign bus.push_ready = cnt_q != CNT_W'(DEPTH);
	assign bus.pop_valid = cnt_q != '0;
	assign bus.pop_data = ent_q[0];
	assign push = bus.push_valid && bus.push_ready;
	assign pop = bus.pop_valid && bus.pop_ready;
	assign slot = cnt_q - CNT_W'(pop);

	// Occupancy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
		end
	end

	// Entry zero is always the oldest; a pop shifts every entry down
	for (genvar e = 0; e < DEPTH; e++) begin : g_ent
		logic [W-1:0] shifted;
		if (e < DEPTH - 1) begin : g_mid
			assign shifted = pop ? ent_q[e+1] : ent_q[e];
		end else begin : g_top
			assign shifted = ent_q[e];
		end
		always_ff @(posedge clk) begin
			if (push && slot == CNT_W'(e)) begin
				ent_q[e] <= bus.push_data;
			end else begin
				ent_q[e] <= shifted;
			end
		end
		assign bus.peek_data[e] = ent_q[e];
		assign bus.peek_valid[e] = cnt_q > CNT_W'(e);
	end
endmodule : dbs_buf2

// ---- rtl/dbs_port_decode.sv ----
// Command decode, burst sequencing and lane masking of a DDR burst SRAM port
`timescale 1ns/1ps
module dbs_port_decode
	import dbs_pkg::*;
#(
	parameter dbs_org_t ORG = DBS_ORG_X36
) (
	// Core clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// True input clock; its falling edge stands for the complementary rise
	input wire logic k_clk,
	// Command pins
	input wire logic load_strobe_n,
	input wire logic rd_not_wr,
	input wire logic [ADDR_W-1:0] addr_in,
	// Shared data pins and lane selects (nibble selects use bits 1:0)
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [SEL_W-1:0] byte_write_select_n,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	// Output clock pins, sensed only as a strap
	input wire logic c_clk,
	input wire logic c_clk_n,
	// Status
	output logic link_ready,
	output logic single_clk_mode
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Expand active-low selects into a per-bit write enable
	function automatic logic [DATA_W-1:0] lane_we(input logic [SEL_W-1:0] sel_n);
		logic [DATA_W-1:0] we;
		int lw;
		int nl;
		we = '0;
		lw = (ORG == DBS_ORG_X8) ? NIB_W : LANE_W;
		nl = (ORG == DBS_ORG_X9) ? 1 : ((ORG == DBS_ORG_X36) ? 4 : 2);
		for (int i = 0; i < DATA_W; i++) begin
			if (i < nl * lw) begin
				we[i] = !sel_n[i / lw]; // RULE9 RULE10 RULE11
			end
		end
		return we;
	endfunction : lane_we

	// Array index of beat b of a burst
	function automatic logic [IDX_W-1:0] beat_idx(input logic [ADDR_W-1:0] a, input logic b);
		logic [IDX_W-1:0] idx;
		if (ORG == DBS_ORG_X8 || ORG == DBS_ORG_X9) begin
			idx = {a, b}; // RULE6
		end else begin
			idx = {1'b0, a[ADDR_W-1:1], a[0] ^ b}; // RULE5
		end
		return idx;
	endfunction : beat_idx

	// Lanes without enable keep the old value, so an all-off mask is a no-op
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw,
		input logic [DATA_W-1:0] we
	);
		return (old & ~we) | (nw & we); // RULE12
	endfunction : merge

	// ------------------------------------------------------------
	// Core domain: power-up and strap sensing
	// ------------------------------------------------------------
	dbs_pwr_t pwr_state_q;
	logic [SETTLE_CNT_W-1:0] settle_cnt_q;
	logic strap_level;
	logic strap_low_q;
	logic single_q;
	logic ready_q;

	// Both pins combined before the chain; resets high so only a real low clears the strap
	dbs_sync3 #(.RST_VAL(1'b1)) u_strap_sync (
		.clk(ref_clk),
		.rst(rst),
		.async_in(c_clk & c_clk_n),
		.level(strap_level)
	);

	// Settle window, then run
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwr_state_q <= PWR_SETTLE;
			settle_cnt_q <= '0;
		end else begin
			case (pwr_state_q)
				PWR_SETTLE: begin
					settle_cnt_q <= settle_cnt_q + SETTLE_CNT_W'(1);
					if (settle_cnt_q == SETTLE_LAST) begin
						pwr_state_q <= PWR_RUN;
					end
				end
				PWR_RUN: begin
					pwr_state_q <= PWR_RUN;
				end
				default: begin
					pwr_state_q <= PWR_SETTLE;
				end
			endcase
		end
	end

	// Strap must read high for the whole window; frozen after it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strap_low_q <= 1'b0;
			single_q <= 1'b0;
		end else if (pwr_state_q == PWR_SETTLE) begin
			if (!strap_level) begin
				strap_low_q <= 1'b1;
			end
			if (settle_cnt_q == SETTLE_LAST) begin
				single_q <= !strap_low_q && strap_level; // RULE18
			end
		end
	end

	// Port stays deselected until the settle window has passed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0; // RULE4
		end else begin
			ready_q <= pwr_state_q == PWR_RUN;
		end
	end

	assign link_ready = ready_q;
	assign single_clk_mode = single_q;

	// ------------------------------------------------------------
	// Link domain: command decode
	// ------------------------------------------------------------
	logic ready_k;
	logic wr_go;
	logic rd_go;
	logic wr_cmd_q;
	logic rd_cmd_q;
	logic [ADDR_W-1:0] cmd_addr_q;

	// Ready crosses as a level; the chain also masks a ragged reset release
	dbs_sync3 #(.RST_VAL(1'b0)) u_ready_sync (
		.clk(k_clk),
		.rst(rst),
		.async_in(ready_q),
		.level(ready_k)
	);

	assign wr_go = ready_k && !load_strobe_n && !rd_not_wr; // RULE1
	assign rd_go = ready_k && !load_strobe_n && rd_not_wr; // RULE2

	// Load high gives an idle slot: neither flag is set
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			wr_cmd_q <= 1'b0;
			rd_cmd_q <= 1'b0; // RULE4
			cmd_addr_q <= '0;
		end else begin
			wr_cmd_q <= wr_go; // RULE3
			rd_cmd_q <= rd_go;
			cmd_addr_q <= addr_in;
		end
	end

	// ------------------------------------------------------------
	// Link domain: write data capture
	// ------------------------------------------------------------
	dbs_buf_if #(.W(BURST_W), .DEPTH(BUF_DEPTH)) post_if ();
	logic wr_stage_q;
	logic rd_stage_q;
	logic [ADDR_W-1:0] stage_addr_q;
	logic wr_hold;
	logic [DATA_W-1:0] d0_q;
	logic [DATA_W-1:0] we0_q;
	logic [DATA_W-1:0] d1_q;
	logic [DATA_W-1:0] we1_q;
	dbs_burst_t push_burst;

	// A full buffer holds the staged burst; the idle slot before a write keeps it rare
	assign wr_hold = wr_stage_q && !post_if.push_ready; // RULE16

	// Stage advance; selects are only looked at in a started write's data slot
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			wr_stage_q <= 1'b0;
			rd_stage_q <= 1'b0;
			stage_addr_q <= '0;
			d0_q <= DQ_RST;
			we0_q <= '0;
		end else begin
			wr_stage_q <= wr_cmd_q || wr_hold;
			rd_stage_q <= rd_cmd_q;
			if (!wr_hold) begin
				stage_addr_q <= cmd_addr_q;
			end
			if (wr_cmd_q && !wr_hold) begin
				d0_q <= dq_in; // RULE1 RULE7
				we0_q <= lane_we(byte_write_select_n); // RULE13 RULE14
			end
		end
	end

	// Second beat on the complementary rise, with its own mask
	always_ff @(negedge k_clk or posedge rst) begin
		if (rst) begin
			d1_q <= DQ_RST;
			we1_q <= '0;
		end else if (wr_stage_q && !wr_hold) begin
			d1_q <= dq_in; // RULE1 RULE7
			we1_q <= lane_we(byte_write_select_n); // RULE13 RULE14
		end
	end

	// ------------------------------------------------------------
	// Posted write buffer and array
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem_q [MEM_DEPTH];
	dbs_burst_t pop_burst;
	dbs_burst_t peek_burst [BUF_DEPTH];

	assign push_burst = '{addr: stage_addr_q, d0: d0_q, d1: d1_q, we0: we0_q, we1: we1_q};
	assign post_if.push_valid = wr_stage_q;
	assign post_if.push_data = push_burst;
	assign pop_burst = post_if.pop_data;

	// Writes wait in the buffer while reads own the array
	assign post_if.pop_ready = !rd_cmd_q && !rd_stage_q; // RULE17

	dbs_buf2 #(.W(BURST_W), .DEPTH(BUF_DEPTH)) u_post (
		.clk(k_clk),
		.rst(rst),
		.bus(post_if.store)
	);

	// Both beats of a burst land together; their indices always differ
	always_ff @(posedge k_clk) begin
		if (post_if.pop_valid && post_if.pop_ready) begin
			mem_q[beat_idx(pop_burst.addr, 1'b0)] <=
				merge(mem_q[beat_idx(pop_burst.addr, 1'b0)], pop_burst.d0, pop_burst.we0);
			mem_q[beat_idx(pop_burst.addr, 1'b1)] <=
				merge(mem_q[beat_idx(pop_burst.addr, 1'b1)], pop_burst.d1, pop_burst.we1);
		end
	end

	// ------------------------------------------------------------
	// Read fetch with bypass of posted writes
	// ------------------------------------------------------------
	logic [IDX_W-1:0] rd_idx0;
	logic [IDX_W-1:0] rd_idx1;
	logic [DATA_W-1:0] rd_word0;
	logic [DATA_W-1:0] rd_word1;

	assign rd_idx0 = beat_idx(stage_addr_q, 1'b0);
	assign rd_idx1 = beat_idx(stage_addr_q, 1'b1);

	for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_peek
		assign peek_burst[e] = post_if.peek_data[e];
	end

	// Oldest entry first so the newest write wins per lane
	always_comb begin
		rd_word0 = mem_q[rd_idx0];
		rd_word1 = mem_q[rd_idx1];
		for (int e = 0; e < BUF_DEPTH; e++) begin
			if (post_if.peek_valid[e]) begin
				if (beat_idx(peek_burst[e].addr, 1'b0) == rd_idx0) begin
					rd_word0 = merge(rd_word0, peek_burst[e].d0, peek_burst[e].we0); // RULE17
				end
				if (beat_idx(peek_burst[e].addr, 1'b1) == rd_idx0) begin
					rd_word0 = merge(rd_word0, peek_burst[e].d1, peek_burst[e].we1);
				end
				if (beat_idx(peek_burst[e].addr, 1'b0) == rd_idx1) begin
					rd_word1 = merge(rd_word1, peek_burst[e].d0, peek_burst[e].we0);
				end
				if (beat_idx(peek_burst[e].addr, 1'b1) == rd_idx1) begin
					rd_word1 = merge(rd_word1, peek_burst[e].d1, peek_burst[e].we1); // RULE17
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read data launch
	// ------------------------------------------------------------
	logic [DATA_W-1:0] q_neg_q;
	logic [DATA_W-1:0] q_pos_q;
	logic oe_neg_q;
	logic oe_pos_q;

	// First word on the complementary rise of the cycle after the command
	always_ff @(negedge k_clk or posedge rst) begin
		if (rst) begin
			q_neg_q <= DQ_RST;
			oe_neg_q <= 1'b0; // RULE4
		end else begin
			oe_neg_q <= rd_stage_q; // RULE3 RULE15
			if (rd_stage_q) begin
				q_neg_q <= rd_word0; // RULE2 RULE7
			end
		end
	end

	// Second word on the following true rise
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			q_pos_q <= DQ_RST;
			oe_pos_q <= 1'b0;
		end else begin
			oe_pos_q <= rd_stage_q; // RULE15
			if (rd_stage_q) begin
				q_pos_q <= rd_word1; // RULE2 RULE7
			end
		end
	end

	// Output mux picks the register of the current phase; with the clock stopped
	// nothing updates and the pins keep their last state
	assign dq_out = k_clk ? q_pos_q : q_neg_q; // RULE8
	assign dq_oe_n = !(k_clk ? oe_pos_q : oe_neg_q); // RULE8

endmodule : dbs_port_decode

// ---- test/dbs_port_decode_asserts.sv ----
// Concurrent checks on the pins of the DDR burst SRAM port decode
`timescale 1ns/1ps
module dbs_port_decode_asserts
	import dbs_pkg::*;
(
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic k_clk,
	// Link pins
	input wire logic load_strobe_n,
	input wire logic rd_not_wr,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [SEL_W-1:0] byte_write_select_n,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe_n,
	// Strap and status
	input wire logic c_clk,
	input wire logic c_clk_n,
	input wire logic link_ready,
	input wire logic single_clk_mode
);
	logic [7:0] rdy_q;
	logic wr_go;
	logic rd_go;

	// Ready seen on eight link rises; earlier commands may still be dropped
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			rdy_q <= 8'h00;
		end else begin
			rdy_q <= {rdy_q[6:0], link_ready};
		end
	end

	// Commands the port must accept
	assign wr_go = &rdy_q && !load_strobe_n && !rd_not_wr;
	assign rd_go = &rdy_q && !load_strobe_n && rd_not_wr;

	// Power-up and strap
	AST_PWR_UP: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(rst) |-> (dq_oe_n && !link_ready)[*8] ##[1:32] link_ready)
		else $error("Port not deselected after reset");
	AST_STRAP_FIXED: assert property (@(posedge ref_clk) disable iff (rst)
		link_ready && $past(link_ready) |-> $stable(single_clk_mode))
		else $error("Clock mode changed while running");

	// Link side; write beats never turn the pins around
	AST_NOT_READY_Z: assert property (@(posedge k_clk) disable iff (rst)
		!link_ready |-> dq_oe_n)
		else $error("Pins driven before ready");
	AST_IDLE_Z: assert property (@(posedge k_clk) disable iff (rst)
		load_strobe_n [*2] |=> dq_oe_n)
		else $error("Pins driven in idle slots");
	AST_READ_ON: assert property (@(posedge k_clk) disable iff (rst)
		rd_go |-> ##2 !dq_oe_n)
		else $error("Read word not driven");
	AST_READ_OFF: assert property (@(posedge k_clk) disable iff (rst)
		rd_go ##1 load_strobe_n [*2] |-> !dq_oe_n ##1 dq_oe_n)
		else $error("Pins not released after read");
	AST_WRITE_QUIET: assert property (@(posedge k_clk) disable iff (rst)
		wr_go |-> ##1 dq_oe_n [*2])
		else $error("Pins driven during write");
	AST_BYPASS: assert property (@(posedge k_clk) disable iff (rst)
		wr_go ##1 (rd_go && addr_in == $past(addr_in) && byte_write_select_n == 4'h0)
		|-> ##2 dq_out == $past(dq_in, 2))
		else $error("Read after write missed newest data");

	// Main scenarios reached
	COV_WRITE: cover property (@(posedge k_clk) wr_go);
	COV_READ: cover property (@(posedge k_clk) rd_go);
	COV_BYPASS: cover property (@(posedge k_clk) wr_go ##1 rd_go);
endmodule : dbs_port_decode_asserts

bind dbs_port_decode dbs_port_decode_asserts i_dbs_port_decode_asserts (
	.ref_clk, .rst, .k_clk, .load_strobe_n, .rd_not_wr, .addr_in, .dq_in,
	.byte_write_select_n, .dq_out, .dq_oe_n, .c_clk, .c_clk_n, .link_ready,
	.single_clk_mode
);

// ---- test/dbs_ctrl_model.sv ----
// Behavioural memory controller on the link side of the port
`timescale 1ns/1ps
module dbs_ctrl_model
	import dbs_pkg::*;
(
	// Link clock and commands
	output logic k_clk,
	output logic load_strobe_n,
	output logic rd_not_wr,
	output logic [ADDR_W-1:0] addr_in,
	// Data pins and lane selects
	output logic [DATA_W-1:0] dq_in,
	output logic [SEL_W-1:0] byte_write_select_n,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe_n
);
	bit k_run = 1'b1;
	logic drv = 1'b0;
	logic [DATA_W-1:0] d = '0;
	logic [DATA_W-1:0] w0;
	logic [DATA_W-1:0] w1;
	logic oe0;
	logic oe1;

	// Link clock, parked high while stopped for the quickest restart
	initial k_clk = 1'b0;
	always #3 k_clk = k_run ? ~k_clk : 1'b1;

	// Idle pins; a released data bus shows the inverse of its last value
	initial begin
		load_strobe_n = 1'b1;
		rd_not_wr = 1'b0;
		addr_in = '0;
		byte_write_select_n = WE_NONE;
	end
	assign dq_in = (dq_oe_n === 1'b0) ? dq_out : drv ? d : ~d;

	// Read words: low phase after rise t+1, then high phase after rise t+2
	task automatic rd_tail();
		@(posedge k_clk);
		@(negedge k_clk);
		#1 w0 = dq_out;
		oe0 = dq_oe_n;
		@(posedge k_clk);
		#1 w1 = dq_out;
		@(negedge k_clk);
		#1 oe1 = dq_oe_n;
	endtask : rd_tail

	// Write burst; rb also loads a read of the same address in cycle t+1
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
		input logic [DATA_W-1:0] d1, input logic [SEL_W-1:0] m0,
		input logic [SEL_W-1:0] m1, input bit rb);
		@(posedge k_clk);
		load_strobe_n <= 1'b0;
		rd_not_wr <= 1'b0;
		addr_in <= a;
		@(posedge k_clk);
		load_strobe_n <= !rb;
		rd_not_wr <= 1'b1;
		drv <= 1'b1;
		d <= d0;
		byte_write_select_n <= m0;
		@(posedge k_clk);
		load_strobe_n <= 1'b1;
		d <= d1;
		byte_write_select_n <= m1;
		@(negedge k_clk);
		drv <= 1'b0;
		byte_write_select_n <= 4'h0; // Stray selects the port has to ignore
		if (rb) rd_tail();
	endtask : wr

	// Single read; each operation opens on a fresh rise, so idle slots follow
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge k_clk);
		load_strobe_n <= 1'b0;
		rd_not_wr <= 1'b1;
		addr_in <= a;
		@(posedge k_clk);
		load_strobe_n <= 1'b1;
		rd_tail();
	endtask : rd
endmodule : dbs_ctrl_model

// ---- test/test_dbs_port_decode.sv ----
// Self-checking bench for the DDR burst SRAM port decode
`timescale 1ns/1ps
module test_dbs_port_decode;
	import dbs_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic c_pins = 1'b0;
	logic k_clk;
	logic load_strobe_n;
	logic rd_not_wr;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] dq_in;
	logic [DATA_W-1:0] dq_out;
	logic [SEL_W-1:0] byte_write_select_n;
	logic dq_oe_n;
	logic link_ready;
	logic single_clk_mode;
	int err_count = 0;
	int checks = 0;
	logic [DATA_W-1:0] mem [64];

	// Output clock straps start low (split clocks); the last scenario ties them high
	dbs_port_decode i_dbs_port_decode (
		.ref_clk, .rst, .k_clk, .load_strobe_n, .rd_not_wr, .addr_in, .dq_in,
		.byte_write_select_n, .dq_out, .dq_oe_n, .c_clk(c_pins), .c_clk_n(c_pins),
		.link_ready, .single_clk_mode
	);
	dbs_ctrl_model ctl (.k_clk, .load_strobe_n, .rd_not_wr, .addr_in, .dq_in,
		.byte_write_select_n, .dq_out, .dq_oe_n);

	// Core clock
	always #12.5 ref_clk = ~ref_clk;

	// ----
	// Helpers
	// ----
	task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// Lane merge of the reference model; a high select keeps the old lane
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
		input logic [DATA_W-1:0] n, input logic [SEL_W-1:0] m);
		merge = o;
		for (int l = 0; l < SEL_W; l++) begin
			if (!m[l]) merge[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
		end
	endfunction : merge

	task automatic wrm(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
		input logic [DATA_W-1:0] d1, input logic [SEL_W-1:0] m0,
		input logic [SEL_W-1:0] m1, input bit rb);
		mem[a] = merge(mem[a], d0, m0);
		mem[a ^ 6'h01] = merge(mem[a ^ 6'h01], d1, m1);
		ctl.wr(a, d0, d1, m0, m1, rb);
	endtask : wrm

	task automatic chk(input logic [ADDR_W-1:0] a);
		cmp(ctl.w0, mem[a]);
		cmp(ctl.w1, mem[a ^ 6'h01]);
		cmp(ctl.oe0, 1'b0);
		cmp(ctl.oe1, 1'b1);
	endtask : chk

	task automatic rdc(input logic [ADDR_W-1:0] a);
		ctl.rd(a);
		chk(a);
	endtask : rdc

	// ----
	// Scenarios
	// ----
	task automatic t_power();
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 64 && link_ready !== 1'b1; i++) @(posedge ref_clk);
		cmp(link_ready, 1'b1);
		cmp(dq_oe_n, 1'b1);
		cmp(single_clk_mode, 1'b0);
		repeat (10) @(posedge k_clk);
	endtask : t_power

	task automatic t_burst();
		wrm(6'h05, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0, 0);
		wrm(6'h10, 36'hFFFFFFFFF, 36'h000000000, 4'h0, 4'h0, 0);
		wrm(6'h20, 36'h0F0F0F0F0, 36'h5A5A5A5A5, 4'h0, 4'h0, 0);
		rdc(6'h04);
		rdc(6'h05);
	endtask : t_burst

	// One lane per beat, a different lane on each beat, one beat fully masked
	task automatic t_lanes();
		for (int i = 0; i < 4; i++) begin
			wrm(6'h10, 36'h2468ACE13 ^ DATA_W'(i), 36'h13579BDF0,
				~(4'h1 << i), (i == 2) ? 4'hF : ~(4'h8 >> i), 0);
			rdc(6'h10);
		end
	endtask : t_lanes

	task automatic t_bypass();
		wrm(6'h21, 36'hC3C3C3C3C, 36'h3C3C3C3C3, 4'h0, 4'hA, 1);
		chk(6'h21);
		wrm(6'h04, 36'h0DEADBEEF, 36'h777000777, 4'h5, 4'h0, 1);
		chk(6'h04);
	endtask : t_bypass

	// Idle slots with stray selects low: pins stay released, array untouched
	task automatic t_idle();
		repeat (20) begin
			@(negedge k_clk);
			#1 cmp(dq_oe_n, 1'b1);
		end
		rdc(6'h10);
	endtask : t_idle

	task automatic t_stop();
		logic [DATA_W-1:0] o;
		@(posedge k_clk);
		ctl.k_run = 1'b0;
		#1 o = dq_out;
		#100;
		cmp(dq_out, o);
		cmp(dq_oe_n, 1'b1);
		ctl.k_run = 1'b1;
		rdc(6'h05);
	endtask : t_stop

	// Second power-up with both output clock pins high selects single clock mode
	task automatic t_strap();
		@(posedge ref_clk);
		c_pins <= 1'b1;
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 64 && link_ready !== 1'b1; i++) @(posedge ref_clk);
		cmp(single_clk_mode, 1'b1);
		cmp(dq_oe_n, 1'b1);
		repeat (10) @(posedge k_clk);
		wrm(6'h30, 36'h1F2E3D4C5, 36'h0A1B2C3D4, 4'h0, 4'h0, 0);
		rdc(6'h30);
	endtask : t_strap

	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		t_power();
		t_burst();
		t_lanes();
		t_bypass();
		t_idle();
		t_stop();
		t_strap();
		end_of_test();
	end

	// Watchdog, far beyond the few microseconds the sequence needs
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
endmodule : test_dbs_port_decode
